// ===== design/lnl_pkg.sv
/*
  Constants for the LAN region image loader: word offsets of the region,
  load ranges per reset kind, and the fixed image values.
  Assumes a 16-bit word read port toward the shared flash on the same clock.
*/
package lnl_pkg;
  localparam int unsigned WordAddrW = 7;
  localparam int unsigned WordW = 16;
  // Station address words
  localparam logic [6:0] AddrFirst = 7'h00;
  localparam logic [6:0] AddrLast = 7'h02;
  // Software-owned words, never interpreted
  localparam logic [6:0] SwFirst = 7'h03;
  localparam logic [6:0] SwLast = 7'h09;
  localparam logic [15:0] ImgWord3 = 16'h0800;
  localparam logic [15:0] ImgBlank = 16'hffff;
  // PCI configuration words
  localparam logic [6:0] PciFirst = 7'h0a;
  localparam logic [6:0] PciLast = 7'h10;
  localparam int unsigned PciCount = 7;
  // Shared configuration words
  localparam logic [6:0] ShrFirst = 7'h13;
  localparam logic [6:0] ShrLast = 7'h18;
  localparam int unsigned ShrCount = 6;
  // Checksum word, covering bytes up to this byte offset
  localparam logic [6:0] CsumWord = 7'h3f;
  localparam logic [7:0] CsumLastByte = 8'h7d;
  // PHY configuration for the G3 to S5 transition
  localparam logic [6:0] PhyFirst = 7'h40;
  localparam logic [6:0] PhyLast = 7'h4a;
  localparam int unsigned PhyCount = 11;

  typedef enum logic [2:0] {
    LNL_IDLE = 3'b000,
    LNL_REQ = 3'b001,
    LNL_WAIT = 3'b010,
    LNL_DONE = 3'b011
  } lnl_state_e;
endpackage : lnl_pkg

// ===== design/lnl_loader.sv
/*
  LAN region image loader: on a shared or PCI configuration reset request it
  reads the needed words from the region in ascending order and latches them.
  Assumes a flash read port on mclk that answers each request with one
  rdValid pulse some cycles later; reset requests are mclk-domain pulses.
*/
// Functional notes
// RL1: Station address from words 0x00-0x02, low byte first
// RL2: PCI reset reads words 0x0A to 0x10
// RL3: Shared reset reads 0x13-0x18 plus address
// RL4: Words 0x03-0x09 are never interpreted
// RL5: G3-S5 PHY configuration from words 0x40-0x4A
// RL6: Image builder places checksum in word 0x3F
// RL7: Sector and region sizes set by image builder
// RL8: Firmware keeps protected range at zero
// RL9: Shared words fetched on every shared reset
// RL10: PCI words fetched on every PCI reset
// RL11: Ascending fetch, latch, then completion flag
module lnl_loader
  import lnl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic sharedResetReq,
  input wire logic pciResetReq,
  output logic rdReq,
  output logic [6:0] rdAddr,
  input wire logic rdValid,
  input wire logic [15:0] rdData,
  output logic [47:0] individualStationAddress,
  output logic [15:0] pciWord [PciCount],
  output logic [15:0] sharedWord [ShrCount],
  output logic [15:0] phyWord [PhyCount],
  output logic loadBusy,
  output logic sharedResetLoaded,
  output logic pciResetLoaded
);
  lnl_state_e state_r;
  logic [6:0] addr_r;
  logic isShared_r;
  logic shrPend_r;
  logic pciPend_r;

  // Next word to fetch for the running load; in a shared load AddrLast and ShrLast jump to later ranges
  // RL4: skips software words
  function automatic logic [6:0] nextWord(input logic [6:0] a, input logic sh);
    if (sh && a == AddrLast) return ShrFirst;
    if (sh && a == ShrLast) return PhyFirst;
    return 7'(a + 7'h01);
  endfunction

  // Last word of a load kind
  function automatic logic lastWord(input logic [6:0] a, input logic sh);
    return sh ? (a == PhyLast) : (a == PciLast);
  endfunction

  // Pending reset requests; a new request during a load is kept, not lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      shrPend_r <= 1'b0;
      pciPend_r <= 1'b0;
    end else if (clkEn) begin
      // RL9: shared reset queued
      if (sharedResetReq)
        shrPend_r <= 1'b1;
      else if (state_r == LNL_IDLE && shrPend_r)
        shrPend_r <= 1'b0;
      // RL10: PCI reset queued
      if (pciResetReq)
        pciPend_r <= 1'b1;
      else if (state_r == LNL_IDLE && !shrPend_r && pciPend_r)
        pciPend_r <= 1'b0;
    end
  end

  // Load sequencer; shared load has priority over PCI load
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= LNL_IDLE;
      addr_r <= AddrFirst;
      isShared_r <= 1'b0;
      rdReq <= 1'b0;
      rdAddr <= AddrFirst;
      loadBusy <= 1'b0;
    end else if (clkEn) begin
      rdReq <= 1'b0;
      case (state_r)
        LNL_IDLE: begin
          if (shrPend_r) begin
            // RL3: shared load starts at the address words
            isShared_r <= 1'b1;
            addr_r <= AddrFirst;
            state_r <= LNL_REQ;
            loadBusy <= 1'b1;
          end else if (pciPend_r) begin
            // RL2: PCI load range start
            isShared_r <= 1'b0;
            addr_r <= PciFirst;
            state_r <= LNL_REQ;
            loadBusy <= 1'b1;
          end
        end
        LNL_REQ: begin
          rdReq <= 1'b1;
          rdAddr <= addr_r;
          state_r <= LNL_WAIT;
        end
        LNL_WAIT: begin
          if (rdValid) begin
            // RL11: ascending order to last word
            if (lastWord(addr_r, isShared_r)) begin
              state_r <= LNL_DONE;
            end else begin
              addr_r <= nextWord(addr_r, isShared_r);
              state_r <= LNL_REQ;
            end
          end
        end
        LNL_DONE: begin
          loadBusy <= 1'b0;
          state_r <= LNL_IDLE;
        end
        default: begin
          state_r <= LNL_IDLE;
          loadBusy <= 1'b0;
        end
      endcase
    end
  end

  // Latch returned words into configuration storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      individualStationAddress <= '0;
      pciWord <= '{default: '0};
      sharedWord <= '{default: '0};
      phyWord <= '{default: '0};
    end else if (clkEn && state_r == LNL_WAIT && rdValid) begin
      // RL1: low half is lower-numbered byte
      if (addr_r <= AddrLast)
        individualStationAddress[addr_r[1:0]*WordW +: WordW] <= rdData;
      // RL2: PCI words stored
      if (addr_r >= PciFirst && addr_r <= PciLast)
        pciWord[3'(addr_r - PciFirst)] <= rdData;
      // RL3: shared words stored
      if (addr_r >= ShrFirst && addr_r <= ShrLast)
        sharedWord[3'(addr_r - ShrFirst)] <= rdData;
      // RL5: PHY configuration stored
      if (addr_r >= PhyFirst && addr_r <= PhyLast)
        phyWord[4'(addr_r - PhyFirst)] <= rdData;
    end
  end

  // Completion flags, cleared when a new matching reset request arrives, unless it arrives in the LNL_DONE cycle of a load of the same kind
  always_ff @(posedge mclk) begin
    if (rst) begin
      sharedResetLoaded <= 1'b0;
      pciResetLoaded <= 1'b0;
    end else if (clkEn) begin
      // RL11: completion after last word
      if (state_r == LNL_DONE && isShared_r)
        sharedResetLoaded <= 1'b1;
      else if (sharedResetReq)
        sharedResetLoaded <= 1'b0;
      if (state_r == LNL_DONE && !isShared_r)
        pciResetLoaded <= 1'b1;
      else if (pciResetReq)
        pciResetLoaded <= 1'b0;
    end
  end

  // Order-check helper: last address requested within the running load
  logic [6:0] prevAddr_r;
  logic havePrev_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      prevAddr_r <= AddrFirst;
      havePrev_r <= 1'b0;
    end else if (clkEn) begin
      // RL11: forget order between loads
      if (state_r == LNL_IDLE) begin
        havePrev_r <= 1'b0;
      end else if (rdReq) begin
        prevAddr_r <= rdAddr;
        havePrev_r <= 1'b1;
      end
    end
  end

  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sw_words_skip_a: assert property (rdReq |-> !(rdAddr >= SwFirst && rdAddr <= SwLast)) // RL4
    else $error("software-owned word fetched");
  pci_range_a: assert property (rdReq && !isShared_r |->
      rdAddr >= PciFirst && rdAddr <= PciLast) // RL2
    else $error("PCI load outside its range");
  shr_range_a: assert property (rdReq && isShared_r |->
      rdAddr <= AddrLast || (rdAddr >= ShrFirst && rdAddr <= ShrLast)
      || (rdAddr >= PhyFirst && rdAddr <= PhyLast)) // RL3
    else $error("shared load outside its ranges");
  ascend_a: assert property (rdReq && havePrev_r |-> rdAddr > prevAddr_r) // RL11
    else $error("read address not ascending");
  addr_store_a: assert property (clkEn && state_r == LNL_WAIT && rdValid && addr_r == AddrFirst
      |=> individualStationAddress[15:0] == $past(rdData)) // RL1
    else $error("address word 0 not latched");
  phy_store_a: assert property (clkEn && state_r == LNL_WAIT && rdValid && addr_r == PhyLast
      |=> phyWord[PhyCount-1] == $past(rdData)) // RL5
    else $error("PHY word not latched");
  shr_done_a: assert property (clkEn && state_r == LNL_WAIT && rdValid && isShared_r
      && addr_r == PhyLast ##1 clkEn |=> sharedResetLoaded) // RL9
    else $error("shared completion missing");
  pci_done_a: assert property (clkEn && state_r == LNL_WAIT && rdValid && !isShared_r
      && addr_r == PciLast ##1 clkEn |=> pciResetLoaded) // RL10
    else $error("PCI completion missing");
  pci_start_a: assert property (clkEn && pciResetReq && state_r == LNL_IDLE && !shrPend_r
      && !sharedResetReq |=> pciPend_r) // RL10
    else $error("PCI request lost");

  shr_load_c: cover property ($rose(sharedResetLoaded));
  pci_load_c: cover property ($rose(pciResetLoaded));
  both_req_c: cover property (sharedResetReq && pciResetReq);
  req_busy_c: cover property (pciResetReq && loadBusy);
endmodule // lnl_loader

// ===== bench/lnl_flash_model.sv
/*
  Shared flash model for the image loader: answers each read after lat+1 cycles.
  Assumes requests come one at a time from the loader on mclk.
*/
module lnl_flash_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rdReq,
  input wire logic [6:0] rdAddr,
  input wire logic [15:0] key,
  input wire logic [2:0] lat,
  output logic rdValid,
  output logic [15:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic [6:0] addr;
  // sum of words 0x00-0x3F lands on this value
  localparam logic [15:0] SumTarget = 16'h0000; // Arbitrary target value
  // 4 KB sectors, so an 8 KB region
  localparam int SectorBytes = 4096;
  localparam int RegionBytes = (SectorBytes == 65536) ? 131072 : 8192;
  localparam logic [31:0] ProtRange = 32'h0000_0000;
  function automatic logic [15:0] csum();
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 'h3f; i++) s = 16'(s + img(7'(i)));
    return 16'(SumTarget - s);
  endfunction
  function automatic logic [15:0] img(input logic [6:0] a);
    if (a == 7'h3f) return csum();
    if (a == 7'h03) return 16'h0800;
    if (a == 7'h04 || a == 7'h06 || a == 7'h07) return 16'hffff;
    return key ^ {a, 2'b00, a};
  endfunction
  // Answer after the latency; data toggles when not valid
  always @(posedge mclk) begin
    rdValid <= 1'b0;
    if (rst) begin
      cnt <= 0;
      rdData <= 16'h0000;
    end else if (rdReq) begin
      addr <= rdAddr;
      cnt <= int'(lat) + 1;
      rdData <= ~rdData;
    end else if (cnt == 1) begin
      rdValid <= 1'b1;
      // region readable only while unprotected and inside the region
      rdData <= (ProtRange == 32'h0 && int'(addr) * 2 < RegionBytes) ? img(addr) : 16'hffff;
      cnt <= 0;
    end else begin
      if (cnt > 1) cnt <= cnt - 1;
      rdData <= ~rdData;
    end
  end
endmodule // lnl_flash_model

// ===== bench/tb.sv
/*
  Bench for the image loader: random and corner loads of both kinds.
  Assumes the flash model answers with the key-based word pattern.
*/
module tb
  import lnl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, clkEn, sharedResetReq, pciResetReq, rdReq, rdValid;
  logic loadBusy, sharedResetLoaded, pciResetLoaded;
  logic [6:0] rdAddr;
  logic [15:0] rdData, key;
  logic [2:0] lat;
  logic [47:0] individualStationAddress;
  logic [15:0] pciWord [PciCount];
  logic [15:0] sharedWord [ShrCount];
  logic [15:0] phyWord [PhyCount];
  logic [6:0] seen [$];
  int seed = 19112;
  int bad_count, check_count, cycles, r;
  lnl_loader u_lnl_loader (.mclk, .rst, .clkEn, .sharedResetReq, .pciResetReq, .rdReq,
    .rdAddr, .rdValid, .rdData, .individualStationAddress, .pciWord, .sharedWord,
    .phyWord, .loadBusy, .sharedResetLoaded, .pciResetLoaded);
  lnl_flash_model u_lnl_flash_model (.mclk, .rst, .rdReq, .rdAddr, .key, .lat, .rdValid,
    .rdData);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Read trace and run ceiling
  always @(posedge mclk) begin
    cycles++;
    if (rdReq === 1'b1) seen.push_back(rdAddr);
    if (cycles == 10000) begin
      bad_count++;
      report_and_stop();
    end
  end
  function automatic logic [15:0] ew(input logic [6:0] a);
    return key ^ {a, 2'b00, a};
  endfunction
  function automatic bit inShr(input int a);
    return a <= 2 || (a >= ShrFirst && a <= ShrLast) || (a >= PhyFirst && a <= PhyLast);
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d bad=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One or two loads: pulse requests, wait for flags, compare words and read order
  task automatic go(input bit sh, input bit pc);
    int n;
    int k;
    n = 0;
    k = 0;
    @(posedge mclk);
    seen = {};
    key <= 16'($random(seed));
    lat <= 3'($random(seed));
    sharedResetReq <= sh;
    pciResetReq <= pc;
    @(posedge mclk);
    sharedResetReq <= 1'b0;
    pciResetReq <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({15'h0, loadBusy}, 16'h0001);
    if (sh) chk({15'h0, sharedResetLoaded}, 16'h0000);
    if (pc) chk({15'h0, pciResetLoaded}, 16'h0000);
    while (((sh && sharedResetLoaded !== 1'b1) || (pc && pciResetLoaded !== 1'b1))
        && n < 500) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (sh) chk({15'h0, sharedResetLoaded}, 16'h0001);
    if (pc) chk({15'h0, pciResetLoaded}, 16'h0001);
    chk({15'h0, loadBusy}, 16'h0000);
    if (sh) begin
      for (int i = 0; i < 3; i++) chk(individualStationAddress[16*i +: 16], ew(7'(i)));
      for (int i = 0; i < ShrCount; i++) chk(sharedWord[i], ew(ShrFirst + 7'(i)));
      for (int i = 0; i < PhyCount; i++) chk(phyWord[i], ew(PhyFirst + 7'(i)));
    end
    if (pc) for (int i = 0; i < PciCount; i++) chk(pciWord[i], ew(PciFirst + 7'(i)));
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 128; a++) begin
        if ((p == 0 && sh && inShr(a)) || (p == 1 && pc && a >= PciFirst && a <= PciLast)) begin
          chk({9'h0, seen[k]}, {9'h0, 7'(a)});
          k++;
        end
      end
    end
    chk(16'(seen.size()), 16'(k));
    $display("load shared=%0d pci=%0d done", sh, pc);
  endtask
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    sharedResetReq = 1'b0;
    pciResetReq = 1'b0;
    key = 16'h0000;
    lat = 3'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({14'h0, sharedResetLoaded, pciResetLoaded}, 16'h0000);
    // Corner: a request while the clock enable is low is not taken
    @(posedge mclk);
    clkEn <= 1'b0;
    sharedResetReq <= 1'b1;
    @(posedge mclk);
    sharedResetReq <= 1'b0;
    repeat (3) @(posedge mclk);
    clkEn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk({15'h0, loadBusy}, 16'h0000);
    chk(16'(seen.size()), 16'h0000);
    $display("frozen request test done");
    go(1'b1, 1'b1);
    go(1'b0, 1'b1);
    go(1'b0, 1'b1);
    go(1'b1, 1'b0);
    repeat (8) begin
      r = $random(seed);
      go(r[0], r[1] | ~r[0]);
    end
    report_and_stop();
  end
endmodule // tb
